// ### rtl/pamon_top.sv
/*
 * PA average power monitor for the main DAC datapaths: squares the top bits
 * of I and Q, averages over a long and a short window, compares with limits
 * and requests a soft off. Per-DAC copies selected by the page register.
 * Assumes mclk is the DAC sample clock, one I/Q sample per DAC per cycle when
 * sample_valid is high, and interpolation settings from same-clock logic.
 */
`timescale 1ns/1ps
module pamon_top
    import pamon_pkg::*;
#(
    parameter int SAMPLE_W = 16
) (
    input  wire logic                      mclk,
    input  wire logic                      rstn,
    input  wire logic [PAMON_AW-1:0]       reg_addr,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    input  wire logic [PAMON_DW-1:0]       reg_wdata,
    output logic      [PAMON_DW-1:0]       reg_rdata,
    input  wire logic [3:0]                main_interp,
    input  wire logic [3:0]                chan_interp,
    input  wire logic                      sample_valid,
    input  wire logic [SAMPLE_W-1:0]       sample_i [PAMON_NDAC],
    input  wire logic [SAMPLE_W-1:0]       sample_q [PAMON_NDAC],
    output logic      [PAMON_NDAC-1:0]     long_error,
    output logic      [PAMON_NDAC-1:0]     short_error,
    output logic      [PAMON_NDAC-1:0]     soft_off_req
);
    localparam int ACC_W = 12 + PAMON_LONG_BASE + 15;

    logic [PAMON_PAGE_W-1:0] converter_page_select_r;
    logic [PAMON_NDAC-1:0]   long_error_ramp_down_on_r;
    logic [PAMON_NDAC-1:0]   short_error_ramp_down_on_r;
    logic [PAMON_NDAC-1:0]   long_window_monitor_on_r;
    logic [PAMON_NDAC-1:0]   short_window_monitor_on_r;
    logic [PAMON_LEXP_W-1:0] long_window_exponent_r [PAMON_NDAC];
    logic [PAMON_SEXP_W-1:0] short_window_exponent_r [PAMON_NDAC];
    logic [PAMON_PWR_W-1:0]  long_window_limit_r [PAMON_NDAC];
    logic [PAMON_PWR_W-1:0]  short_window_limit_r [PAMON_NDAC];
    logic [PAMON_PWR_W-1:0]  long_window_power_readback_r [PAMON_NDAC];
    logic [PAMON_PWR_W-1:0]  short_window_power_readback_r [PAMON_NDAC];
    logic [ACC_W-1:0]        long_acc_r [PAMON_NDAC];
    logic [23:0]             long_cnt_r [PAMON_NDAC];
    logic [2:0]              short_cnt_r [PAMON_NDAC];
    logic [7:0]              tick_cnt_r;
    logic [7:0]              pa_period;
    logic                    pa_tick;
    logic [11:0]             inst_power [PAMON_NDAC];
    logic [PAMON_NDAC-1:0]   long_end;
    logic [PAMON_NDAC-1:0]   short_end;
    logic [ACC_W-1:0]        long_sum [PAMON_NDAC];
    logic [PAMON_PWR_W-1:0]  long_avg [PAMON_NDAC];
    logic [4:0]              long_shift [PAMON_NDAC];
    logic                    rd_dac;

    // pa clock period in dac clocks, from interpolation settings
    always_comb begin
        if (main_interp > 4'h1) begin
            pa_period = PAMON_PER_MAIN_K * {4'h0, main_interp};
        end else if (chan_interp > 4'h1) begin
            pa_period = PAMON_PER_CHAN_K * {4'h0, main_interp};
        end else begin
            pa_period = PAMON_PER_BYPASS;
        end
    end

    assign pa_tick = (tick_cnt_r >= pa_period - 8'h01);

    // >= so a period shrinking mid-count cannot strand the divider
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_r <= 8'h00;
        end else if (pa_tick) begin
            tick_cnt_r <= 8'h00;
        end else begin
            tick_cnt_r <= tick_cnt_r + 8'h01;
        end
    end

    // cycles since a bypass tick; a counter keeps the period check cheap to unroll
    logic       byp_mode;
    logic [7:0] byp_gap_r;
    assign byp_mode = (main_interp <= 4'h1) && (chan_interp <= 4'h1);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            byp_gap_r <= 8'h00;
        end else if (!byp_mode) begin
            byp_gap_r <= 8'h00;
        end else if (pa_tick) begin
            byp_gap_r <= 8'h01;
        end else if (byp_gap_r != 8'h00 && byp_gap_r != 8'hFF) begin
            byp_gap_r <= byp_gap_r + 8'h01;
        end
    end

    // power is decimated to one sample per pa clock, the unregistered square sum feeds the sums
    genvar g;
    generate
        for (g = 0; g < PAMON_NDAC; g++) begin : g_dac
            logic signed [PAMON_TOP_BITS-1:0] i_top;
            logic signed [PAMON_TOP_BITS-1:0] q_top;
            logic signed [11:0]               i_sq;
            logic signed [11:0]               q_sq;
            assign i_top = sample_i[g][SAMPLE_W-1 -: PAMON_TOP_BITS];
            assign q_top = sample_q[g][SAMPLE_W-1 -: PAMON_TOP_BITS];
            assign i_sq  = i_top * i_top;
            assign q_sq  = q_top * q_top;
            assign inst_power[g] = sample_valid ? 12'(i_sq + q_sq) : 12'h000;
            assign long_shift[g] = 5'(PAMON_LONG_BASE) + {1'b0, long_window_exponent_r[g]};
            assign long_end[g]   = pa_tick && long_window_monitor_on_r[g]
                                 && (long_cnt_r[g] == 24'((25'h1 << long_shift[g]) - 25'h1));
            assign short_end[g]  = pa_tick && short_window_monitor_on_r[g]
                                 && (short_cnt_r[g] == 3'((4'h1 << short_window_exponent_r[g]) - 4'h1));
            assign long_sum[g]   = long_acc_r[g] + ACC_W'(inst_power[g]);
            assign long_avg[g]   = PAMON_PWR_W'(long_sum[g] >> long_shift[g]);
        end
    endgenerate

    // accumulators are kept narrow: short sum holds raw power of up to 8 ticks
    logic [14:0] short_full_r [PAMON_NDAC];

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            for (int d = 0; d < PAMON_NDAC; d++) begin
                long_acc_r[d]   <= '0;
                long_cnt_r[d]   <= 24'h000000;
                short_full_r[d] <= 15'h0000;
                short_cnt_r[d]  <= 3'h0;
            end
        end else begin
            for (int d = 0; d < PAMON_NDAC; d++) begin
                if (!long_window_monitor_on_r[d]) begin
                    long_acc_r[d] <= '0;
                    long_cnt_r[d] <= 24'h000000;
                end else if (pa_tick) begin
                    long_acc_r[d] <= long_end[d] ? '0 : long_sum[d];
                    long_cnt_r[d] <= long_end[d] ? 24'h000000 : long_cnt_r[d] + 24'h000001;
                end
                if (!short_window_monitor_on_r[d]) begin
                    short_full_r[d] <= 15'h0000;
                    short_cnt_r[d]  <= 3'h0;
                end else if (pa_tick) begin
                    short_full_r[d] <= short_end[d] ? 15'h0000 : short_full_r[d] + {3'h0, inst_power[d]};
                    short_cnt_r[d]  <= short_end[d] ? 3'h0 : short_cnt_r[d] + 3'h1;
                end
            end
        end
    end

    logic [14:0]            short_tot [PAMON_NDAC];
    logic [PAMON_PWR_W-1:0] short_avg_t [PAMON_NDAC];
    always_comb begin
        for (int d = 0; d < PAMON_NDAC; d++) begin
            short_tot[d]   = short_full_r[d] + {3'h0, inst_power[d]};
            short_avg_t[d] = PAMON_PWR_W'(short_tot[d] >> short_window_exponent_r[d]);
        end
    end

    // readback refreshes only at window end; error flags update there and clear while the monitor is off
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            long_error  <= '0;
            short_error <= '0;
            for (int d = 0; d < PAMON_NDAC; d++) begin
                long_window_power_readback_r[d]  <= '0;
                short_window_power_readback_r[d] <= '0;
            end
        end else begin
            for (int d = 0; d < PAMON_NDAC; d++) begin
                if (!long_window_monitor_on_r[d]) begin
                    long_error[d] <= 1'b0;
                end else if (long_end[d]) begin
                    long_window_power_readback_r[d] <= long_avg[d];
                    long_error[d] <= (long_avg[d] > long_window_limit_r[d]);
                end
                if (!short_window_monitor_on_r[d]) begin
                    short_error[d] <= 1'b0;
                end else if (short_end[d]) begin
                    short_window_power_readback_r[d] <= short_avg_t[d];
                    short_error[d] <= (short_avg_t[d] > short_window_limit_r[d]);
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            soft_off_req <= '0;
        end else begin
            soft_off_req <= (long_error & long_error_ramp_down_on_r)
                          | (short_error & short_error_ramp_down_on_r);
        end
    end

    // writes go to every paged copy whose page bit is set
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            converter_page_select_r    <= PAMON_PAGE_RST;
            long_error_ramp_down_on_r  <= {PAMON_NDAC{PAMON_RAMP_RST}};
            short_error_ramp_down_on_r <= {PAMON_NDAC{PAMON_RAMP_RST}};
            long_window_monitor_on_r   <= {PAMON_NDAC{PAMON_ON_RST}};
            short_window_monitor_on_r  <= {PAMON_NDAC{PAMON_ON_RST}};
            for (int d = 0; d < PAMON_NDAC; d++) begin
                long_window_exponent_r[d]  <= '0;
                short_window_exponent_r[d] <= '0;
                long_window_limit_r[d]     <= '0;
                short_window_limit_r[d]    <= '0;
            end
        end else if (reg_wr) begin
            if (reg_addr == PAMON_A_PAGE) begin
                converter_page_select_r <= reg_wdata[PAMON_PAGE_W-1:0];
            end
            for (int d = 0; d < PAMON_NDAC; d++) begin
                if (converter_page_select_r[d]) begin
                    if (reg_addr == PAMON_A_RAMP_ENA) begin
                        short_error_ramp_down_on_r[d] <= reg_wdata[PAMON_B_SHORT_RAMP];
                        long_error_ramp_down_on_r[d]  <= reg_wdata[PAMON_B_LONG_RAMP];
                    end else if (reg_addr == PAMON_A_LLIM_LO) begin
                        long_window_limit_r[d][7:0] <= reg_wdata;
                    end else if (reg_addr == PAMON_A_LLIM_HI) begin
                        long_window_limit_r[d][12:8] <= reg_wdata[PAMON_HI_W-1:0];
                    end else if (reg_addr == PAMON_A_LCTRL) begin
                        long_window_monitor_on_r[d] <= reg_wdata[PAMON_B_ON];
                        long_window_exponent_r[d]   <= reg_wdata[PAMON_LEXP_W-1:0];
                    end else if (reg_addr == PAMON_A_SLIM_LO) begin
                        short_window_limit_r[d][7:0] <= reg_wdata;
                    end else if (reg_addr == PAMON_A_SLIM_HI) begin
                        short_window_limit_r[d][12:8] <= reg_wdata[PAMON_HI_W-1:0];
                    end else if (reg_addr == PAMON_A_SCTRL) begin
                        short_window_monitor_on_r[d] <= reg_wdata[PAMON_B_ON];
                        short_window_exponent_r[d]   <= reg_wdata[PAMON_SEXP_W-1:0];
                    end
                end
            end
        end
    end

    // reads come from the lowest selected page
    assign rd_dac = !converter_page_select_r[0] && converter_page_select_r[1];

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == PAMON_A_PAGE) begin
                reg_rdata <= {6'h00, converter_page_select_r};
            end else if (reg_addr == PAMON_A_RAMP_ENA) begin
                reg_rdata <= {short_error_ramp_down_on_r[rd_dac], long_error_ramp_down_on_r[rd_dac], 6'h00};
            end else if (reg_addr == PAMON_A_LLIM_LO) begin
                reg_rdata <= long_window_limit_r[rd_dac][7:0];
            end else if (reg_addr == PAMON_A_LLIM_HI) begin
                reg_rdata <= {3'h0, long_window_limit_r[rd_dac][12:8]};
            end else if (reg_addr == PAMON_A_LCTRL) begin
                reg_rdata <= {long_window_monitor_on_r[rd_dac], 3'h0, long_window_exponent_r[rd_dac]};
            end else if (reg_addr == PAMON_A_LPWR_LO) begin
                reg_rdata <= long_window_power_readback_r[rd_dac][7:0];
            end else if (reg_addr == PAMON_A_LPWR_HI) begin
                reg_rdata <= {3'h0, long_window_power_readback_r[rd_dac][12:8]};
            end else if (reg_addr == PAMON_A_SLIM_LO) begin
                reg_rdata <= short_window_limit_r[rd_dac][7:0];
            end else if (reg_addr == PAMON_A_SLIM_HI) begin
                reg_rdata <= {3'h0, short_window_limit_r[rd_dac][12:8]};
            end else if (reg_addr == PAMON_A_SCTRL) begin
                reg_rdata <= {short_window_monitor_on_r[rd_dac], 5'h00, short_window_exponent_r[rd_dac]};
            end else if (reg_addr == PAMON_A_SPWR_LO) begin
                reg_rdata <= short_window_power_readback_r[rd_dac][7:0];
            end else if (reg_addr == PAMON_A_SPWR_HI) begin
                reg_rdata <= {3'h0, short_window_power_readback_r[rd_dac][12:8]};
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    chk_tick_spacing: assert property (@(posedge mclk) disable iff (!rstn)
        pa_tick |=> !pa_tick [*3]) else $error("pa tick spacing below four");
    chk_bypass_period: assert property (@(posedge mclk) disable iff (!rstn)
        byp_mode && byp_gap_r == PAMON_PER_BYPASS |-> pa_tick)
        else $error("bypass pa period not 32");
    chk_short_gate: assert property (@(posedge mclk) disable iff (!rstn)
        !short_window_monitor_on_r[0] |=> short_cnt_r[0] == 3'h0 && !short_error[0])
        else $error("short monitor active while off");
    chk_long_gate: assert property (@(posedge mclk) disable iff (!rstn)
        !long_window_monitor_on_r[0] |=> long_cnt_r[0] == 24'h000000 && !long_error[0])
        else $error("long monitor active while off");
    chk_long_compare: assert property (@(posedge mclk) disable iff (!rstn)
        long_end[0] |=> long_error[0] == ($past(long_avg[0]) > $past(long_window_limit_r[0])))
        else $error("long error disagrees with limit");
    chk_short_compare: assert property (@(posedge mclk) disable iff (!rstn)
        short_end[0] |=> short_error[0] == ($past(short_avg_t[0]) > $past(short_window_limit_r[0])))
        else $error("short error disagrees with limit");
    chk_readback_hold: assert property (@(posedge mclk) disable iff (!rstn)
        !long_end[0] |=> $stable(long_window_power_readback_r[0]))
        else $error("long readback changed mid window");
    chk_soft_off_long: assert property (@(posedge mclk) disable iff (!rstn)
        long_error[0] && long_error_ramp_down_on_r[0] |=> soft_off_req[0])
        else $error("long error did not request soft off");
    chk_soft_off_short: assert property (@(posedge mclk) disable iff (!rstn)
        short_error[1] && short_error_ramp_down_on_r[1] |=> soft_off_req[1])
        else $error("short error did not request soft off");
    chk_paged_read: assert property (@(posedge mclk) disable iff (!rstn)
        reg_rd && reg_addr == PAMON_A_SPWR_LO && converter_page_select_r == 2'h2
        |=> reg_rdata == $past(short_window_power_readback_r[1][7:0]))
        else $error("paged readback from wrong copy");
endmodule

// ### rtl/pamon_pkg.sv
/*
 * Constants of the PA average power monitor: register addresses, field
 * positions, reset values and PA clock period factors.
 * Assumes an 8-bit register port with 12-bit addresses.
 */
package pamon_pkg;
    localparam int          PAMON_NDAC          = 2;
    localparam int          PAMON_AW            = 12;
    localparam int          PAMON_DW            = 8;
    localparam int          PAMON_PWR_W         = 13;
    localparam int          PAMON_TOP_BITS      = 6;
    localparam int          PAMON_LONG_BASE     = 9;

    localparam logic [11:0] PAMON_A_PAGE        = 12'h008;
    localparam logic [11:0] PAMON_A_RAMP_ENA    = 12'h581;
    localparam logic [11:0] PAMON_A_LLIM_LO     = 12'h583;
    localparam logic [11:0] PAMON_A_LLIM_HI     = 12'h584;
    localparam logic [11:0] PAMON_A_LCTRL       = 12'h585;
    localparam logic [11:0] PAMON_A_LPWR_LO     = 12'h586;
    localparam logic [11:0] PAMON_A_LPWR_HI     = 12'h587;
    localparam logic [11:0] PAMON_A_SLIM_LO     = 12'h588;
    localparam logic [11:0] PAMON_A_SLIM_HI     = 12'h589;
    localparam logic [11:0] PAMON_A_SCTRL       = 12'h58A;
    localparam logic [11:0] PAMON_A_SPWR_LO     = 12'h58B;
    localparam logic [11:0] PAMON_A_SPWR_HI     = 12'h58C;

    localparam int          PAMON_B_ON          = 7;
    localparam int          PAMON_B_SHORT_RAMP  = 7;
    localparam int          PAMON_B_LONG_RAMP   = 6;
    localparam int          PAMON_HI_W          = 5;
    localparam int          PAMON_LEXP_W        = 4;
    localparam int          PAMON_SEXP_W        = 2;
    localparam int          PAMON_PAGE_W        = 2;

    localparam logic [1:0]  PAMON_PAGE_RST      = 2'h1;
    localparam logic        PAMON_RAMP_RST      = 1'b1;
    localparam logic        PAMON_ON_RST        = 1'b0;

    localparam logic [7:0]  PAMON_PER_MAIN_K    = 8'h04;
    localparam logic [7:0]  PAMON_PER_CHAN_K    = 8'h08;
    localparam logic [7:0]  PAMON_PER_BYPASS    = 8'h20;
endpackage

// ### testbench/pamon_src.sv
/*
 * Model of the main datapath I/Q sample bus that feeds the power monitor.
 * Assumes the bench picks the six top bits of each DAC's I and Q samples.
 */
`timescale 1ns/1ps
module pamon_src
    import pamon_pkg::*;
#(
    parameter int SAMPLE_W = 16
) (
    input  wire logic                mclk,
    input  wire logic                valid_on,
    input  wire logic [5:0]          top_i [PAMON_NDAC],
    input  wire logic [5:0]          top_q [PAMON_NDAC],
    output logic                     sample_valid,
    output logic [SAMPLE_W-1:0]      sample_i [PAMON_NDAC],
    output logic [SAMPLE_W-1:0]      sample_q [PAMON_NDAC]
);
    localparam int LOW_W = SAMPLE_W - PAMON_TOP_BITS;
    // low bits churn every cycle; idle bus churns whole, never a stale value
    always @(negedge mclk) begin
        sample_valid <= valid_on;
        for (int d = 0; d < PAMON_NDAC; d++) begin
            sample_i[d] <= valid_on ? {top_i[d], LOW_W'($urandom)} : SAMPLE_W'($urandom);
            sample_q[d] <= valid_on ? {top_q[d], LOW_W'($urandom)} : SAMPLE_W'($urandom);
        end
    end
endmodule

// ### testbench/pamon_top_test.sv
/*
 * Self-checking bench for the PA average power monitor.
 * Assumes the register port contract of the design and steady top bits per window.
 */
`timescale 1ns/1ps
module pamon_top_test;
    import pamon_pkg::*;
    logic              mclk = 1'b0;
    logic              rstn;
    logic [11:0]       reg_addr;
    logic              reg_wr;
    logic              reg_rd;
    logic [7:0]        reg_wdata;
    logic [7:0]        reg_rdata;
    logic [3:0]        main_interp;
    logic [3:0]        chan_interp;
    logic              valid_on;
    logic [5:0]        top_i [PAMON_NDAC];
    logic [5:0]        top_q [PAMON_NDAC];
    logic              sample_valid;
    logic [15:0]       sample_i [PAMON_NDAC];
    logic [15:0]       sample_q [PAMON_NDAC];
    logic [1:0]        long_error;
    logic [1:0]        short_error;
    logic [1:0]        soft_off_req;
    logic              rd_pend = 1'b0;
    logic [12:0]       pw;
    logic [7:0]        exp_q [$];
    string             nam_q [$];
    int                failures = 0;
    int                checked = 0;
    int                mains [4] = '{2, 1, 1, 3};
    int                chans [4] = '{1, 2, 1, 1};
    int                pers [4] = '{8, 8, 32, 12};
    logic [11:0]       zero_a [11] = '{PAMON_A_LLIM_LO, PAMON_A_LLIM_HI, PAMON_A_LCTRL, PAMON_A_LPWR_LO,
                                       PAMON_A_LPWR_HI, PAMON_A_SLIM_LO, PAMON_A_SLIM_HI, PAMON_A_SCTRL,
                                       PAMON_A_SPWR_LO, PAMON_A_SPWR_HI, 12'h000};
    pamon_top u_pamon_top (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .main_interp(main_interp), .chan_interp(chan_interp),
        .sample_valid(sample_valid), .sample_i(sample_i), .sample_q(sample_q), .long_error(long_error),
        .short_error(short_error), .soft_off_req(soft_off_req));
    pamon_src u_pamon_src (.mclk(mclk), .valid_on(valid_on), .top_i(top_i), .top_q(top_q),
        .sample_valid(sample_valid), .sample_i(sample_i), .sample_q(sample_q));
    initial begin
        forever #50 mclk = ~mclk;
    end
    task automatic summarize();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic check_win(input string nm, input int lo, input int hi, input int g);
        checked++;
        if (g < lo || g > hi) begin
            failures++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e, input string nm);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        exp_q.push_back(e);
        nam_q.push_back(nm);
        @(negedge mclk);
        reg_rd = 1'b0;
    endtask
    // answer is registered: compare in the cycle after the read was taken
    always @(posedge mclk) rd_pend <= reg_rd;
    always @(negedge mclk) begin
        if (rd_pend === 1'b1) check_byte(nam_q.pop_front(), exp_q.pop_front(), reg_rdata);
    end
    function automatic logic [12:0] pwr(input logic [5:0] i, input logic [5:0] q);
        int si;
        int sq;
        si = int'($signed(i));
        sq = int'($signed(q));
        return 13'(si * si + sq * sq);
    endfunction
    task automatic set_lim(input logic [11:0] a, input logic [12:0] v);
        wr(a, v[7:0]);
        wr(a + 12'h001, {3'h0, v[12:8]});
    endtask
    task automatic time_err(input logic lng, input int d, input int p, input int n, input string nm);
        int c;
        c = 0;
        while ((lng ? long_error[d] : short_error[d]) !== 1'b1 && c < n * p + 8) begin
            @(negedge mclk);
            c++;
        end
        check_win(nm, (n - 1) * p, n * p + 4, c);
    endtask
    initial begin
        #(100 * 40000);
        failures++;
        summarize();
    end
    initial begin
        void'($urandom(88));
        {reg_addr, reg_wr, reg_rd, reg_wdata, rstn} = '0;
        main_interp = 4'h2;
        chan_interp = 4'h1;
        valid_on = 1'b1;
        top_i[0] = 6'($urandom) | 6'h01;
        top_q[0] = 6'($urandom);
        top_i[1] = 6'($urandom) | 6'h02;
        top_q[1] = 6'($urandom);
        repeat (16) @(negedge mclk);
        rstn = 1'b1;
        rd(PAMON_A_PAGE, 8'h01, "page reset");
        rd(PAMON_A_RAMP_ENA, 8'hC0, "ramp enables reset");
        foreach (zero_a[k]) rd(zero_a[k], 8'h00, "reset zero");
        wr(PAMON_A_LPWR_LO, 8'hFF);
        rd(PAMON_A_LPWR_LO, 8'h00, "long readback ro");
        wr(PAMON_A_SLIM_HI, 8'hFF);
        rd(PAMON_A_SLIM_HI, 8'h1F, "short limit hi");
        wr(PAMON_A_SCTRL, 8'h7F);
        rd(PAMON_A_SCTRL, 8'h03, "short ctrl");
        wr(PAMON_A_LCTRL, 8'h7F);
        rd(PAMON_A_LCTRL, 8'h0F, "long ctrl");
        wr(PAMON_A_LCTRL, 8'h00);
        $display("test registers done");
        pw = pwr(top_i[0], top_q[0]);
        set_lim(PAMON_A_SLIM_LO, pw - 13'h0001);
        for (int k = 0; k < 4; k++) begin
            wr(PAMON_A_SCTRL, 8'h00);
            repeat (3) @(negedge mclk);
            check_byte("short err off", 8'h00, {7'h0, short_error[0]});
            main_interp = 4'(mains[k]);
            chan_interp = 4'(chans[k]);
            wr(PAMON_A_SCTRL, 8'h82);
            time_err(1'b0, 0, pers[k], 4, "short window");
            rd(PAMON_A_SPWR_LO, pw[7:0], "short pwr lo");
            rd(PAMON_A_SPWR_HI, {3'h0, pw[12:8]}, "short pwr hi");
            check_byte("soft off short", 8'h01, {7'h0, soft_off_req[0]});
        end
        set_lim(PAMON_A_SLIM_LO, pw);
        repeat (60) @(negedge mclk);
        check_byte("short err at limit", 8'h00, {7'h0, short_error[0]});
        set_lim(PAMON_A_SLIM_LO, pw - 13'h0001);
        wr(PAMON_A_RAMP_ENA, 8'h40);
        repeat (60) @(negedge mclk);
        check_byte("short err masked", 8'h01, {7'h0, short_error[0]});
        check_byte("soft off masked", 8'h00, {7'h0, soft_off_req[0]});
        wr(PAMON_A_RAMP_ENA, 8'hC0);
        valid_on = 1'b0;
        repeat (120) @(negedge mclk);
        rd(PAMON_A_SPWR_LO, 8'h00, "idle pwr lo");
        rd(PAMON_A_SPWR_HI, 8'h00, "idle pwr hi");
        valid_on = 1'b1;
        wr(PAMON_A_SCTRL, 8'h00);
        $display("test short window done");
        main_interp = 4'h2;
        set_lim(PAMON_A_LLIM_LO, pw - 13'h0001);
        wr(PAMON_A_LCTRL, 8'h80);
        time_err(1'b1, 0, 8, 512, "long window");
        rd(PAMON_A_LPWR_LO, pw[7:0], "long pwr lo");
        rd(PAMON_A_LPWR_HI, {3'h0, pw[12:8]}, "long pwr hi");
        check_byte("soft off long", 8'h01, {7'h0, soft_off_req[0]});
        wr(PAMON_A_LCTRL, 8'h00);
        repeat (3) @(negedge mclk);
        check_byte("long err off", 8'h00, {7'h0, long_error[0]});
        $display("test long window done");
        pw = pwr(top_i[1], top_q[1]);
        wr(PAMON_A_PAGE, 8'h02);
        set_lim(PAMON_A_SLIM_LO, pw - 13'h0001);
        wr(PAMON_A_SCTRL, 8'h80);
        time_err(1'b0, 1, 8, 1, "dac1 window");
        rd(PAMON_A_SPWR_LO, pw[7:0], "dac1 pwr lo");
        check_byte("dac0 quiet", 8'h00, {7'h0, short_error[0]});
        check_byte("dac1 soft off", 8'h01, {7'h0, soft_off_req[1]});
        check_byte("dac1 long quiet", 8'h00, {7'h0, long_error[1]});
        wr(PAMON_A_PAGE, 8'h01);
        rd(PAMON_A_SCTRL, 8'h00, "dac0 ctrl");
        $display("test page done");
        summarize();
    end
endmodule
